// ---- ppl_level_decode.sv ----
// Purpose: Turns a lock level setting into four access permissions.
// Assumes: Level values are valid settings; others grant nothing.
// Notes:   Levels n and 100+n share one permission set.
`timescale 1ns/1ps
module ppl_level_decode
  import ppl_pkg::*;
(
  input  wire logic [ppl_pkg::VAL_W-1:0] level_i,  // Lock level setting.
  output logic                           lrd_o,    // Local read allowed.
  output logic                           lwr_o,    // Local write allowed.
  output logic                           nrd_o,    // Network read allowed.
  output logic                           nwr_o     // Network write allowed.
);

  logic [VAL_W-1:0] base;

  always_comb begin
    base = (level_i > VAL_EXT_BASE) ? level_i - VAL_EXT_BASE : level_i;
    {lrd_o, lwr_o, nrd_o, nwr_o} = 4'h0;
    if (level_i == VAL_NO_LOCK) begin
      {lrd_o, lwr_o, nrd_o, nwr_o} = 4'hF;
    end else begin
      case (base)
        14'h0001: {lrd_o, lwr_o, nrd_o, nwr_o} = 4'hA;
        14'h0002: {lrd_o, lwr_o, nrd_o, nwr_o} = 4'hB;
        14'h0003: {lrd_o, lwr_o, nrd_o, nwr_o} = 4'hE;
        14'h0004: {lrd_o, lwr_o, nrd_o, nwr_o} = 4'h0;
        14'h0005: {lrd_o, lwr_o, nrd_o, nwr_o} = 4'h3;
        14'h0006: {lrd_o, lwr_o, nrd_o, nwr_o} = 4'hC;
        default:  {lrd_o, lwr_o, nrd_o, nwr_o} = 4'h0;
      endcase
    end
  end

endmodule

// ---- ppl_panel_model.sv ----
// Purpose: Access master for the local panel, handheld unit and network link.
// Assumes: A request is a one-cycle pulse answered one cycle later.
// Notes:   Qualifiers flip once released so stale values never look valid.
`timescale 1ns/1ps
module ppl_panel_model
  import ppl_pkg::*;
(
  input  wire logic            clk_sys_i, // System clock.
  input  wire logic            done_i,    // Access decided.
  input  wire logic            grant_i,   // Access allowed.
  input  wire logic            ind_i,     // Lock indication.
  output logic                 valid_o,   // Access request.
  output logic                 write_o,   // Request is a write.
  output ppl_pkg::ppl_src_type src_o,     // Requesting unit.
  output logic [3:0]           flags_o    // Hide, protect, internal, contrast.
);
  initial begin
    valid_o = 1'b0;
    write_o = 1'b0;
    src_o   = PPL_SRC_NONE;
    flags_o = 4'h0;
  end

  // Returns done, grant and indication as seen in the answer cycle.
  task automatic access(input logic w, input ppl_src_type s, input logic [3:0] f,
                        output logic [2:0] r);
    @(posedge clk_sys_i);
    valid_o <= 1'b1;
    write_o <= w;
    src_o   <= s;
    flags_o <= f;
    @(posedge clk_sys_i);
    valid_o <= 1'b0;
    write_o <= ~w;
    src_o   <= ppl_src_type'(~s);
    flags_o <= ~f;
    #1 r = {done_i, grant_i, ind_i};
  endtask
endmodule

// ---- ppl_password_lock.sv ----
// Purpose: Password lock gating parameter reads and writes from local and network sources.
// Assumes: All inputs come from logic on clk_sys_i; access requests are one-cycle strobes.
// Notes:   Registers: lock level, password entry, status, control (clear and copy commands).
`timescale 1ns/1ps
module ppl_password_lock
  import ppl_pkg::*;
(
  input  wire logic                     clk_sys_i,                     // System clock, 125 MHz.
  input  wire logic                     rst_n_i,                       // Synchronous reset, active low.
  input  wire logic [ppl_pkg::ADDR_W-1:0] addr_i,                      // Register byte address.
  input  wire logic [ppl_pkg::DATA_W-1:0] wr_data_i,                   // Register write data.
  input  wire logic                     wr_i,                          // Register write strobe.
  input  wire logic                     rd_i,                          // Register read strobe.
  output logic [ppl_pkg::DATA_W-1:0]    rd_data_o,                     // Read data, cycle after rd_i.
  input  wire logic                     acc_valid_i,                   // Parameter access request.
  input  wire logic                     acc_write_i,                   // Access is a write.
  input  wire ppl_pkg::ppl_src_type     acc_src_i,                     // Unit making the access.
  input  wire ppl_pkg::ppl_src_type     local_command_source_select_i, // Unit acting as local source.
  input  wire logic                     net_mode_i,                    // Network operation mode active.
  input  wire logic                     extended_display_hide_i,       // Parameter hidden from reading.
  input  wire logic                     write_protect_deny_i,          // Parameter write protected.
  input  wire logic                     acc_internal_i,                // Device's own update.
  input  wire logic                     acc_contrast_i,                // Target is the contrast setting.
  input  wire logic                     handheld_connected_i,          // Handheld unit fitted.
  input  wire logic                     output_running_i,              // Output voltage is driven.
  output logic                          acc_done_o,                    // Access decided, one pulse.
  output logic                          acc_grant_o,                   // Access allowed, with acc_done_o.
  output logic                          lock_indication_o,             // Denied by the password lock.
  output logic                          full_clear_o,                  // Full parameter clear pulse.
  output logic                          partial_clear_o,               // Partial parameter clear pulse.
  output logic                          copy_o,                        // Parameter copy pulse.
  output logic                          handheld_jog_operation_en_o,   // Handheld jog allowed.
  output logic                          easy_mode_switch_en_o,         // Easy setting mode switch allowed.
  output logic                          locked_o                       // Password registered.
);

  ////////////////////////////////////////////////////////////////////////////
  // State and permission decode.

  logic [VAL_W-1:0] lock_level_reg;
  logic [VAL_W-1:0] password_reg;
  logic             registered_reg;
  logic [CNT_W-1:0] err_cnt_reg;
  logic             lrd;
  logic             lwr;
  logic             nrd;
  logic             nwr;
  logic             ext_level;
  logic             lockout;
  logic [VAL_W-1:0] wr_val;
  logic             wr_level;
  logic             wr_pw;
  logic             wr_ctl;
  logic             full_clr_ok;
  logic             pw_match;

  ppl_level_decode u_decode (
    .level_i (lock_level_reg),
    .lrd_o   (lrd),
    .lwr_o   (lwr),
    .nrd_o   (nrd),
    .nwr_o   (nwr)
  );

  assign ext_level   = (lock_level_reg > VAL_EXT_BASE) && (lock_level_reg != VAL_NO_LOCK);
  assign lockout     = ext_level && (err_cnt_reg == ERR_LIMIT);
  assign wr_val      = wr_data_i[VAL_W-1:0];
  assign wr_level    = wr_i && (addr_i == OFS_LOCK_LEVEL);
  assign wr_pw       = wr_i && (addr_i == OFS_PASSWORD);
  assign wr_ctl      = wr_i && (addr_i == OFS_CONTROL);
  assign full_clr_ok = wr_ctl && wr_data_i[CTL_FULL_CLR] && !output_running_i;
  assign pw_match    = (wr_data_i[DATA_W-1:VAL_W] == '0) && (wr_val == password_reg);

  function automatic logic level_valid(input logic [VAL_W-1:0] v);
    logic [VAL_W-1:0] b;
    b = (v > VAL_EXT_BASE) ? v - VAL_EXT_BASE : v;
    return (v == VAL_NO_LOCK) || ((b >= 14'h0001) && (b <= VAL_LVL_MAX) && (v <= VAL_EXT_BASE + VAL_LVL_MAX));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Lock level setting. Writes are dropped rather than errored; software sees
  // the refusal by reading the value back.

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || full_clr_ok) begin
      lock_level_reg <= LOCK_LEVEL_RST;
    end else if (wr_level && !registered_reg && (wr_data_i[DATA_W-1:VAL_W] == '0) && level_valid(wr_val)) begin
      lock_level_reg <= wr_val;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Password registration, unlock and error counting.

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || full_clr_ok) begin
      password_reg   <= PASSWORD_RST;
      registered_reg <= 1'b0;
    end else if (wr_pw) begin
      if (!registered_reg) begin
        if ((lock_level_reg != VAL_NO_LOCK) && (wr_data_i[DATA_W-1:VAL_W] == '0) &&
            (wr_val >= VAL_PW_MIN) && (wr_val <= VAL_PW_MAX)) begin
          password_reg   <= wr_val;
          registered_reg <= 1'b1;
        end
      end else if (pw_match && !lockout) begin
        password_reg   <= PASSWORD_RST;
        registered_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || full_clr_ok) begin
      err_cnt_reg <= ERR_CNT_RST;
    end else if (wr_pw && registered_reg) begin
      if (pw_match && !lockout) begin
        err_cnt_reg <= ERR_CNT_RST;
      end else if (!pw_match && (err_cnt_reg != ERR_LIMIT)) begin
        err_cnt_reg <= err_cnt_reg + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clear and copy commands.

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      full_clear_o    <= 1'b0;
      partial_clear_o <= 1'b0;
      copy_o          <= 1'b0;
    end else begin
      full_clear_o    <= full_clr_ok;
      partial_clear_o <= wr_ctl && wr_data_i[CTL_PART_CLR] && !registered_reg && !output_running_i;
      copy_o          <= wr_ctl && wr_data_i[CTL_COPY] && !registered_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parameter access gating. The two selector restrictions are applied after the
  // lock; they deny silently because they are not password denials.

  logic src_local;
  logic src_net;
  logic pw_allow;
  logic sel_allow;
  logic bypass;

  always_comb begin
    src_local = (acc_src_i == local_command_source_select_i) && (acc_src_i != PPL_SRC_NONE);
    src_net   = (acc_src_i == PPL_SRC_NETWORK) && net_mode_i && !src_local;
    bypass    = acc_internal_i || (acc_contrast_i && handheld_connected_i);
    pw_allow  = 1'b0;
    if (!registered_reg) begin
      pw_allow = src_local || src_net;
    end else if (src_local) begin
      pw_allow = acc_write_i ? lwr : lrd;
    end else if (src_net) begin
      pw_allow = acc_write_i ? nwr : nrd;
    end
    sel_allow = acc_write_i ? !write_protect_deny_i : !extended_display_hide_i;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      acc_done_o        <= 1'b0;
      acc_grant_o       <= 1'b0;
      lock_indication_o <= 1'b0;
    end else begin
      acc_done_o        <= acc_valid_i;
      acc_grant_o       <= acc_valid_i && (acc_internal_i || (bypass ? 1'b1 : pw_allow) && sel_allow);
      lock_indication_o <= acc_valid_i && !bypass && registered_reg && (src_local || src_net) && !pw_allow;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operator feature enables.

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      handheld_jog_operation_en_o <= 1'b1;
      easy_mode_switch_en_o       <= 1'b1;
      locked_o                    <= 1'b0;
    end else begin
      handheld_jog_operation_en_o <= !(registered_reg && !lrd && !lwr);
      easy_mode_switch_en_o       <= !(registered_reg && !lwr);
      locked_o                    <= registered_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port. Data stand for exactly one cycle.

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !rd_i) begin
      rd_data_o <= '0;
    end else begin
      case (addr_i)
        OFS_LOCK_LEVEL: rd_data_o <= {18'h0_0000, lock_level_reg};
        OFS_PASSWORD: begin
          if (!registered_reg) begin
            rd_data_o <= {18'h0_0000, PASSWORD_RST};
          end else if (ext_level) begin
            rd_data_o <= {29'h000_0000, err_cnt_reg};
          end else begin
            rd_data_o <= '0;
          end
        end
        OFS_STATUS: rd_data_o <= {24'h00_0000, 1'b0, err_cnt_reg, 2'h0, lockout, registered_reg};
        default: rd_data_o <= '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence wrong_pw_s;
    wr_pw && registered_reg && !pw_match;
  endsequence

  sequence clear_refused_s;
    wr_ctl && wr_data_i[CTL_FULL_CLR] && output_running_i;
  endsequence

  level_frozen_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    registered_reg && wr_level && !full_clr_ok |=> $stable(lock_level_reg))
    else $error("Lock level changed while a password is registered.");

  pw_no_level_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_pw && (lock_level_reg == VAL_NO_LOCK) |=> !registered_reg)
    else $error("Password registered with no lock level.");

  pw_read_range_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    rd_i && (addr_i == OFS_PASSWORD) && registered_reg |=> rd_data_o <= 32'h0000_0005)
    else $error("Password entry read exposed more than the error count.");

  lockout_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    lockout && registered_reg && wr_pw |=> registered_reg)
    else $error("Lock released during lockout.");

  err_count_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    wrong_pw_s ##0 (err_cnt_reg < ERR_LIMIT) |=> err_cnt_reg == $past(err_cnt_reg) + 3'h1)
    else $error("Unlock error not counted.");

  clear_run_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    clear_refused_s |=> !full_clear_o)
    else $error("Full clear performed while output runs.");

  clear_release_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    full_clr_ok |=> full_clear_o && !registered_reg && (lock_level_reg == VAL_NO_LOCK)
    ##1 (full_clear_o == $past(full_clr_ok)))
    else $error("Full clear did not release the lock.");

  internal_pass_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    acc_valid_i && acc_internal_i |=> acc_done_o && acc_grant_o)
    else $error("Internal update was blocked.");

  lock_ind_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    lock_indication_o |-> acc_done_o && !acc_grant_o)
    else $error("Lock indication on a granted access.");

  jog_block_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    registered_reg && ((lock_level_reg == 14'h0004) || (lock_level_reg == 14'h0069)) |=> !handheld_jog_operation_en_o)
    else $error("Handheld jog left enabled under lock.");

  perm_open_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (lock_level_reg == VAL_NO_LOCK) |-> lrd && lwr && nrd && nwr)
    else $error("Unlocked level did not grant every access.");

  perm_none_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    ((lock_level_reg == 14'h0004) || (lock_level_reg == 14'h0068)) |-> !lrd && !lwr && !nrd && !nwr)
    else $error("Fully locked level granted an access.");

  perm_net_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    ((lock_level_reg == 14'h0005) || (lock_level_reg == 14'h0069)) |-> !lrd && !lwr && nrd && nwr)
    else $error("Network-only level decoded wrongly.");

  perm_local_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    ((lock_level_reg == 14'h0006) || (lock_level_reg == 14'h006A)) |-> lrd && lwr && !nrd && !nwr)
    else $error("Local-only level decoded wrongly.");

  hide_read_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    acc_valid_i && !acc_write_i && extended_display_hide_i && !acc_internal_i |=> !acc_grant_o)
    else $error("Hidden parameter was read.");

  protect_write_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    acc_valid_i && acc_write_i && write_protect_deny_i && !acc_internal_i |=> !acc_grant_o)
    else $error("Write-protected parameter was written.");

  foreign_src_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    acc_valid_i && !acc_internal_i && !(acc_contrast_i && handheld_connected_i) &&
    (acc_src_i != local_command_source_select_i) && !((acc_src_i == PPL_SRC_NETWORK) && net_mode_i)
    |=> !acc_grant_o)
    else $error("Access from an unselected source was granted.");

  count_hidden_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    rd_i && (addr_i == OFS_PASSWORD) && registered_reg && !ext_level |=> rd_data_o == 32'h0000_0000)
    else $error("Error count shown at a plain lock level.");

  pw_register_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_pw && !registered_reg && (lock_level_reg != VAL_NO_LOCK) && (wr_data_i[DATA_W-1:VAL_W] == '0) &&
    (wr_val >= VAL_PW_MIN) && (wr_val <= VAL_PW_MAX) |=> registered_reg && (password_reg == $past(wr_val)))
    else $error("Valid password was not registered.");

  lock_cause_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    acc_valid_i && registered_reg && src_local && !bypass && !(acc_write_i ? lwr : lrd) |=> lock_indication_o)
    else $error("Lock denial without lock indication.");

  contrast_pass_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    acc_valid_i && acc_contrast_i && handheld_connected_i && !acc_write_i && !extended_display_hide_i
    |=> acc_grant_o)
    else $error("Contrast setting blocked with handheld fitted.");

  unlock_clean_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_pw && registered_reg && pw_match && !lockout |=> !registered_reg && (err_cnt_reg == ERR_CNT_RST))
    else $error("Correct password did not release the lock.");

  err_saturate_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    wrong_pw_s ##0 (err_cnt_reg == ERR_LIMIT) |=> err_cnt_reg == ERR_LIMIT)
    else $error("Unlock error count wrapped.");

  part_copy_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    registered_reg && wr_ctl |=> !partial_clear_o && !copy_o)
    else $error("Partial clear or copy performed under lock.");

  easy_block_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    registered_reg && !lwr |=> !easy_mode_switch_en_o)
    else $error("Easy mode switch left enabled under lock.");

endmodule

// ---- ppl_pkg.sv ----
// Purpose: Shared constants for the parameter password lock.
// Assumes: 32-bit register port, byte addresses on word boundaries.
// Notes:   Lock values are decimal parameter settings held in 14 bits.
package ppl_pkg;

  localparam int          VAL_W          = 14;
  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 32;
  localparam int          CNT_W          = 3;

  localparam logic [7:0]  OFS_LOCK_LEVEL = 8'h00;
  localparam logic [7:0]  OFS_PASSWORD   = 8'h04;
  localparam logic [7:0]  OFS_STATUS     = 8'h08;
  localparam logic [7:0]  OFS_CONTROL    = 8'h0C;

  localparam logic [13:0] VAL_NO_LOCK    = 14'h270F;  // 9999
  localparam logic [13:0] VAL_PW_MIN     = 14'h03E8;  // 1000
  localparam logic [13:0] VAL_PW_MAX     = 14'h270E;  // 9998
  localparam logic [13:0] VAL_EXT_BASE   = 14'h0064;  // 100, counting levels sit above it
  localparam logic [13:0] VAL_LVL_MAX    = 14'h0006;  // 6
  localparam logic [13:0] LOCK_LEVEL_RST = 14'h270F;
  localparam logic [13:0] PASSWORD_RST   = 14'h270F;
  localparam logic [2:0]  ERR_LIMIT      = 3'h5;
  localparam logic [2:0]  ERR_CNT_RST    = 3'h0;

  localparam int          CTL_FULL_CLR   = 0;
  localparam int          CTL_PART_CLR   = 1;
  localparam int          CTL_COPY       = 2;

  typedef enum logic [1:0] {
    PPL_SRC_PANEL    = 2'h0,
    PPL_SRC_HANDHELD = 2'h1,
    PPL_SRC_NETWORK  = 2'h2,
    PPL_SRC_NONE     = 2'h3
  } ppl_src_type;

endpackage

// ---- tb_parameter_password_lock.sv ----
// Purpose: Self-checking bench for the parameter password lock.
// Assumes: Register port answers reads one cycle after the strobe.
// Notes:   Clear and copy pulses are counted, not timed, to stay latency-proof.
`timescale 1ns/1ps
module tb_parameter_password_lock;
  import ppl_pkg::*;
  localparam logic [31:0] PW        = 32'h0000_04D2;
  localparam logic [31:0] NOLK      = 32'h0000_270F;
  localparam logic [3:0]  PERM[1:6] = '{4'hA, 4'hB, 4'hE, 4'h0, 4'h3, 4'hC};
  logic clk_sys_i = 1'b0;
  logic rst_n_i, wr_i, rd_i, net_mode_i, hh_con, running;
  logic [7:0]  addr_i;
  logic [31:0] wr_data_i, rd_data_o, d;
  logic [2:0]  r;
  logic [3:0]  flags;
  logic        valid, wrt, done, grant, ind, fc_o, pc_o, cp_o, jog_en, easy_en, locked_o;
  ppl_src_type src, lsel;
  int error_cnt = 0, checks = 0, cyc = 0, fc = 0, pc = 0, cp = 0;

  always #4 clk_sys_i = ~clk_sys_i;

  ppl_password_lock u_dut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .acc_valid_i(valid), .acc_write_i(wrt),
    .acc_src_i(src), .local_command_source_select_i(lsel), .net_mode_i(net_mode_i),
    .extended_display_hide_i(flags[3]), .write_protect_deny_i(flags[2]),
    .acc_internal_i(flags[1]), .acc_contrast_i(flags[0]), .handheld_connected_i(hh_con),
    .output_running_i(running), .acc_done_o(done), .acc_grant_o(grant),
    .lock_indication_o(ind), .full_clear_o(fc_o), .partial_clear_o(pc_o), .copy_o(cp_o),
    .handheld_jog_operation_en_o(jog_en), .easy_mode_switch_en_o(easy_en), .locked_o(locked_o));

  ppl_panel_model u_part (
    .clk_sys_i(clk_sys_i), .done_i(done), .grant_i(grant), .ind_i(ind),
    .valid_o(valid), .write_o(wrt), .src_o(src), .flags_o(flags));

  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys_i);
    addr_i    <= a;
    wr_data_i <= v;
    wr_i      <= 1'b1;
    @(posedge clk_sys_i);
    wr_i      <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    rd_i   <= 1'b0;
    #1 v = rd_data_o;
  endtask

  task automatic settle;
    repeat (2) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Pulses are tallied so a late or doubled pulse still shows up in the counts.
  always @(posedge clk_sys_i) begin
    cyc++;
    fc += int'(fc_o === 1'b1);
    pc += int'(pc_o === 1'b1);
    cp += int'(cp_o === 1'b1);
    if (cyc == 5000) begin
      error_cnt++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////
  initial begin
    rst_n_i = 1'b0; addr_i = 8'h00; wr_data_i = 32'h0000_0000; wr_i = 1'b0; rd_i = 1'b0;
    lsel = PPL_SRC_PANEL; net_mode_i = 1'b1; hh_con = 1'b0; running = 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rd(OFS_LOCK_LEVEL, d); chk(d, NOLK);
    @(posedge clk_sys_i);
    #1 chk(rd_data_o, 32'h0000_0000);
    rd(OFS_PASSWORD, d); chk(d, NOLK);
    rd(8'h10, d); chk(d, 32'h0000_0000);
    chk({locked_o, jog_en, easy_en}, 32'h0000_0003);
    wr(OFS_PASSWORD, PW);
    rd(OFS_STATUS, d); chk(d, 32'h0000_0000);
    $display("test reset_and_refusal done");
    for (int n = 1; n <= 6; n++) begin
      wr(OFS_LOCK_LEVEL, n);
      wr(OFS_PASSWORD, PW);
      settle();
      chk(locked_o, 1);
      rd(OFS_PASSWORD, d); chk(d, 0);
      wr(OFS_LOCK_LEVEL, 32'h0000_0069);
      rd(OFS_LOCK_LEVEL, d); chk(d, n);
      wr(OFS_CONTROL, 32'h0000_0006);
      for (int j = 0; j < 4; j++) begin
        u_part.access(j[0], (j < 2) ? PPL_SRC_PANEL : PPL_SRC_NETWORK, 4'h0, r);
        chk(r, {1'b1, PERM[n][3-j], ~PERM[n][3-j]});
      end
      chk(jog_en, (n != 4 && n != 5));
      chk(easy_en, PERM[n][2]);
      wr(OFS_PASSWORD, PW);
      settle();
      chk(locked_o, 0);
    end
    chk(pc + cp, 0);
    $display("test level_table done");
    wr(OFS_LOCK_LEVEL, 32'h0000_0004);
    wr(OFS_PASSWORD, PW);
    u_part.access(1'b1, PPL_SRC_PANEL, 4'h2, r); chk(r, 32'h0000_0006);
    @(posedge clk_sys_i);
    hh_con <= 1'b1;
    lsel   <= PPL_SRC_HANDHELD;
    u_part.access(1'b0, PPL_SRC_HANDHELD, 4'h1, r); chk(r, 32'h0000_0006);
    u_part.access(1'b0, PPL_SRC_HANDHELD, 4'h0, r); chk(r, 32'h0000_0005);
    u_part.access(1'b0, PPL_SRC_PANEL, 4'h0, r); chk(r, 32'h0000_0004);
    @(posedge clk_sys_i);
    hh_con <= 1'b0;
    lsel   <= PPL_SRC_PANEL;
    wr(OFS_PASSWORD, PW);
    u_part.access(1'b0, PPL_SRC_PANEL, 4'h8, r); chk(r, 32'h0000_0004);
    u_part.access(1'b1, PPL_SRC_PANEL, 4'h4, r); chk(r, 32'h0000_0004);
    @(posedge clk_sys_i);
    net_mode_i <= 1'b0;
    u_part.access(1'b0, PPL_SRC_NETWORK, 4'h0, r); chk(r, 32'h0000_0004);
    @(posedge clk_sys_i);
    net_mode_i <= 1'b1;
    $display("test bypass_and_masks done");
    wr(OFS_LOCK_LEVEL, 32'h0000_0065);
    wr(OFS_PASSWORD, NOLK);
    rd(OFS_STATUS, d); chk(d, 32'h0000_0000);
    wr(OFS_PASSWORD, PW);
    repeat (6) wr(OFS_PASSWORD, 32'h0000_0457);
    rd(OFS_PASSWORD, d); chk(d, 5);
    wr(OFS_PASSWORD, PW);
    rd(OFS_STATUS, d); chk(d, 32'h0000_0053);
    @(posedge clk_sys_i);
    running <= 1'b1;
    wr(OFS_CONTROL, 32'h0000_0001);
    rd(OFS_LOCK_LEVEL, d); chk(d, 32'h0000_0065);
    wr(OFS_CONTROL, 32'h0000_0002);
    running <= 1'b0;
    wr(OFS_CONTROL, 32'h0000_0001);
    settle();
    chk(fc, 1);
    chk(locked_o, 0);
    rd(OFS_LOCK_LEVEL, d); chk(d, NOLK);
    rd(OFS_STATUS, d); chk(d, 32'h0000_0000);
    wr(OFS_CONTROL, 32'h0000_0002);
    wr(OFS_CONTROL, 32'h0000_0004);
    settle();
    chk(pc, 1);
    chk(cp, 1);
    $display("test lockout_and_clear done");
    stop_test();
  end
endmodule
